// [verilog/nvc_pkg.sv]
// Package for the nonvolatile configuration and common-level register bank.
// Holds the target addresses, register indices, bit positions and reset values.
// Assumes the serial link has been decoded into byte requests upstream.
package nvc_pkg;

  // ==========================================================================
  // Bus targets and register indices
  localparam logic [6:0] CFG_TARGET = 7'h20;
  localparam logic [6:0] COMMON_LEVEL_CODE_TARGET = 7'h28;
  localparam logic [7:0] UPPER_OFS = 8'h13;
  localparam logic [7:0] LOWER_OFS = 8'h14;
  localparam logic [7:0] USER_OFS = 8'h15;
  localparam logic [7:0] CTRL_OFS = 8'hff;
  localparam logic [7:0] VDATA_OFS = 8'h00;
  localparam logic [7:0] VCTRL_OFS = 8'h02;

  // ==========================================================================
  // Field positions
  localparam int TRIG_BIT = 7;
  localparam int RSEL_BIT = 0;
  localparam int SSEL_BIT = 7;

  // ==========================================================================
  // Reset values
  localparam logic [7:0] USER_RST = 8'h00;
  localparam logic [3:0] UPPER_RST = 4'h0;
  localparam logic [3:0] LOWER_RST = 4'h7;
  localparam logic [6:0] CODE_RST = 7'h40;
  localparam logic [7:0] READ_ZERO = 8'h00;

  // ==========================================================================
  // Copy timing
  localparam int CNT_W = 20;
  localparam logic [CNT_W-1:0] COPY_CYCLES_DEF = 20'h003e8;

  // Controller states, one-hot
  typedef enum logic [1:0] {
    NVC_IDLE = 2'b01,
    NVC_COPY = 2'b10
  } nvc_state_e;

endpackage : nvc_pkg

// [verilog/nvc_regs.sv]
// Register bank: user byte, nonvolatile copy control, limit fields and the
// common-level code with its initial and working stores.
// Assumes byte requests arrive as one-cycle strobes synchronous to I_MCLK.
//
// Notes on behaviour
// - The user byte is read and written freely and drives nothing.
// - Writing 1 to the trigger bit of the control register copies volatile contents to storage.
// - The trigger bit clears itself when the copy has finished.
// - Control bits 6 to 1 drop written data and read as zero.
// - The read-select bit makes user and limit reads return volatile contents at 0, stored copies at 1.
// - The level code sits in bits 6 to 0 and scales linearly between limits, 127 being full scale.
// - Bit 7 of the level data register reads 0 and the host writes it as 0.
// - The level registers answer at their own target address, data at index 00h.
// - The level store control register is write-only and reads give nothing back.
// - With store select 0 a data write loads both stores and a read returns the initial store.
// - With store select 1 a data write loads only the working store and reads return it.
// - The upper and lower 4-bit limit fields bound the level output range.
`timescale 1ns/10ps
module nvc_regs #(
  parameter logic [nvc_pkg::CNT_W-1:0] COPY_CYCLES = nvc_pkg::COPY_CYCLES_DEF
) (
  input wire logic I_MCLK,
  input wire logic I_RST,
  input wire logic i_WR,
  input wire logic i_RD,
  input wire logic [6:0] i_TARGET,
  input wire logic [7:0] i_ADDR,
  input wire logic [7:0] i_WDATA,
  output logic [7:0] o_RDATA,
  output logic o_RVALID,
  output logic o_ACK,
  output logic o_COPY_BUSY,
  output logic [6:0] o_LEVEL_CODE,
  output logic [3:0] o_UPPER_LIMIT,
  output logic [3:0] o_LOWER_LIMIT
);

  // ==========================================================================
  // State
  typedef struct packed {
    nvc_pkg::nvc_state_e state;
    logic [nvc_pkg::CNT_W-1:0] cnt;
    logic trig;
    logic rsel;
    logic ssel;
    logic [7:0] user;
    logic [7:0] nv_user;
    logic [3:0] upper;
    logic [3:0] nv_upper;
    logic [3:0] lower;
    logic [3:0] nv_lower;
    logic [6:0] init_store;
    logic [6:0] work_store;
    logic [7:0] rdata;
    logic rvalid;
    logic ack;
  } nvc_st_s;

  nvc_st_s st_reg;
  nvc_st_s st_next;

  // Unit step for the copy counter, sized to match it so no bits are padded
  localparam logic [nvc_pkg::CNT_W-1:0] CNT_STEP = {{(nvc_pkg::CNT_W-1){1'b0}}, 1'b1};

  // ==========================================================================
  // Request decode
  logic cfg_hit;
  logic common_level_code_hit;
  logic w_ctrl;
  logic w_user;
  logic w_upper;
  logic w_lower;
  logic w_vdata;
  logic w_vctrl;
  logic mapped;

  always_comb begin
    cfg_hit = (i_TARGET == nvc_pkg::CFG_TARGET);
    common_level_code_hit = (i_TARGET == nvc_pkg::COMMON_LEVEL_CODE_TARGET);
    w_ctrl = i_WR && cfg_hit && (i_ADDR == nvc_pkg::CTRL_OFS);
    w_user = i_WR && cfg_hit && (i_ADDR == nvc_pkg::USER_OFS);
    w_upper = i_WR && cfg_hit && (i_ADDR == nvc_pkg::UPPER_OFS);
    w_lower = i_WR && cfg_hit && (i_ADDR == nvc_pkg::LOWER_OFS);
    w_vdata = i_WR && common_level_code_hit && (i_ADDR == nvc_pkg::VDATA_OFS);
    w_vctrl = i_WR && common_level_code_hit && (i_ADDR == nvc_pkg::VCTRL_OFS);
    mapped = (cfg_hit && (i_ADDR == nvc_pkg::CTRL_OFS || i_ADDR == nvc_pkg::USER_OFS ||
              i_ADDR == nvc_pkg::UPPER_OFS || i_ADDR == nvc_pkg::LOWER_OFS)) ||
             (common_level_code_hit && (i_ADDR == nvc_pkg::VDATA_OFS || i_ADDR == nvc_pkg::VCTRL_OFS));
  end

  // ==========================================================================
  // Next-state logic
  always_comb begin
    st_next = st_reg;
    st_next.rvalid = 1'b0;
    st_next.ack = (i_WR || i_RD) && mapped;

    if (w_user) begin
      st_next.user = i_WDATA;
    end
    if (w_upper) begin
      st_next.upper = i_WDATA[3:0];
    end
    if (w_lower) begin
      st_next.lower = i_WDATA[3:0];
    end

    // only bits 7 and 0 are kept
    if (w_ctrl) begin
      st_next.rsel = i_WDATA[nvc_pkg::RSEL_BIT];
    end

    // store select is write-only; low bits ignored
    if (w_vctrl) begin
      st_next.ssel = i_WDATA[nvc_pkg::SSEL_BIT];
    end

    if (w_vdata) begin
      st_next.work_store = i_WDATA[6:0];
      // select 0 loads both stores; select 1 working only
      if (!st_reg.ssel) begin
        st_next.init_store = i_WDATA[6:0];
      end
    end

    // Copy sequencer; a trigger while busy is absorbed, bit already set
    case (st_reg.state)
      nvc_pkg::NVC_IDLE: begin
        // start copy; a zero starts nothing
        if (w_ctrl && i_WDATA[nvc_pkg::TRIG_BIT]) begin
          st_next.trig = 1'b1;
          st_next.cnt = COPY_CYCLES - CNT_STEP;
          st_next.state = nvc_pkg::NVC_COPY;
        end
      end
      nvc_pkg::NVC_COPY: begin
        if (st_reg.cnt == '0) begin
          // commit volatile contents at the end of programming
          st_next.nv_user = st_reg.user;
          st_next.nv_upper = st_reg.upper;
          st_next.nv_lower = st_reg.lower;
          st_next.trig = 1'b0;
          st_next.state = nvc_pkg::NVC_IDLE;
        end else begin
          st_next.cnt = st_reg.cnt - CNT_STEP;
        end
      end
      default: begin
        st_next.state = nvc_pkg::NVC_IDLE;
        st_next.trig = 1'b0;
      end
    endcase

    // Read mux, unmapped reads return zero
    if (i_RD) begin
      st_next.rvalid = 1'b1;
      st_next.rdata = nvc_pkg::READ_ZERO;
      if (cfg_hit) begin
        case (i_ADDR)
          nvc_pkg::CTRL_OFS: st_next.rdata = {st_reg.trig, 6'h00, st_reg.rsel};
          // select between volatile and stored copies
          nvc_pkg::USER_OFS: st_next.rdata = st_reg.rsel ? st_reg.nv_user : st_reg.user;
          nvc_pkg::UPPER_OFS: st_next.rdata = {4'h0, st_reg.rsel ? st_reg.nv_upper : st_reg.upper};
          nvc_pkg::LOWER_OFS: st_next.rdata = {4'h0, st_reg.rsel ? st_reg.nv_lower : st_reg.lower};
          default: st_next.rdata = nvc_pkg::READ_ZERO;
        endcase
      end else if (common_level_code_hit && i_ADDR == nvc_pkg::VDATA_OFS) begin
        // bit 7 reads zero; store chosen by select
        st_next.rdata = {1'b0, st_reg.ssel ? st_reg.work_store : st_reg.init_store};
      end
    end
  end

  // ==========================================================================
  // State register
  always_ff @(posedge I_MCLK) begin
    if (I_RST) begin
      st_reg.state <= nvc_pkg::NVC_IDLE;
      st_reg.cnt <= '0;
      st_reg.trig <= 1'b0;
      st_reg.rsel <= 1'b0;
      st_reg.ssel <= 1'b0;
      st_reg.user <= nvc_pkg::USER_RST;
      st_reg.nv_user <= nvc_pkg::USER_RST;
      st_reg.upper <= nvc_pkg::UPPER_RST;
      st_reg.nv_upper <= nvc_pkg::UPPER_RST;
      st_reg.lower <= nvc_pkg::LOWER_RST;
      st_reg.nv_lower <= nvc_pkg::LOWER_RST;
      st_reg.init_store <= nvc_pkg::CODE_RST;
      st_reg.work_store <= nvc_pkg::CODE_RST;
      st_reg.rdata <= nvc_pkg::READ_ZERO;
      st_reg.rvalid <= 1'b0;
      st_reg.ack <= 1'b0;
    end else begin
      st_reg <= st_next;
    end
  end

  // ==========================================================================
  // Outputs, straight from flops
  // working store drives the level converter code
  assign o_LEVEL_CODE = st_reg.work_store;
  assign o_UPPER_LIMIT = st_reg.upper;
  assign o_LOWER_LIMIT = st_reg.lower;
  assign o_RDATA = st_reg.rdata;
  assign o_RVALID = st_reg.rvalid;
  assign o_ACK = st_reg.ack;
  assign o_COPY_BUSY = st_reg.trig;

  // ==========================================================================
  // Assertions
  a_trigger_starts: assert property (@(posedge I_MCLK) disable iff (I_RST)
    (w_ctrl && i_WDATA[7] && st_reg.state == nvc_pkg::NVC_IDLE) |=>
      (st_reg.trig && st_reg.state == nvc_pkg::NVC_COPY && st_reg.cnt == COPY_CYCLES - CNT_STEP))
    else $error("copy did not start on trigger write");

  a_copy_self_clear: assert property (@(posedge I_MCLK) disable iff (I_RST)
    (st_reg.state == nvc_pkg::NVC_COPY && st_reg.cnt == '0) |=>
      (!st_reg.trig && st_reg.nv_user == $past(st_reg.user)))
    else $error("trigger not cleared or copy not committed");

  a_zero_no_copy: assert property (@(posedge I_MCLK) disable iff (I_RST)
    (w_ctrl && !i_WDATA[7] && st_reg.state == nvc_pkg::NVC_IDLE) |=>
      (!st_reg.trig && $stable(st_reg.nv_user)))
    else $error("zero trigger write started a copy");

  a_ctrl_reserved: assert property (@(posedge I_MCLK) disable iff (I_RST)
    (i_RD && cfg_hit && i_ADDR == nvc_pkg::CTRL_OFS) |=> (o_RVALID && o_RDATA[6:1] == 6'h00))
    else $error("reserved control bits not zero");

  a_read_select: assert property (@(posedge I_MCLK) disable iff (I_RST)
    (i_RD && cfg_hit && i_ADDR == nvc_pkg::USER_OFS) |=>
      (o_RDATA == ($past(st_reg.rsel) ? $past(st_reg.nv_user) : $past(st_reg.user))))
    else $error("user read ignored read select");

  a_user_write: assert property (@(posedge I_MCLK) disable iff (I_RST)
    w_user |=> (st_reg.user == $past(i_WDATA)))
    else $error("user byte not stored");

  a_level_bit7: assert property (@(posedge I_MCLK) disable iff (I_RST)
    (i_RD && common_level_code_hit && i_ADDR == nvc_pkg::VDATA_OFS) |=> !o_RDATA[7])
    else $error("level data bit 7 not zero");

  a_vctrl_wo: assert property (@(posedge I_MCLK) disable iff (I_RST)
    (i_RD && common_level_code_hit && i_ADDR == nvc_pkg::VCTRL_OFS) |=> (o_RDATA == 8'h00))
    else $error("write-only register returned data");

  a_sel0_both: assert property (@(posedge I_MCLK) disable iff (I_RST)
    (w_vdata && !st_reg.ssel) |=>
      (st_reg.init_store == $past(i_WDATA[6:0]) && o_LEVEL_CODE == $past(i_WDATA[6:0])))
    else $error("select 0 write did not load both stores");

  a_sel1_work: assert property (@(posedge I_MCLK) disable iff (I_RST)
    (w_vdata && st_reg.ssel) |=> ($stable(st_reg.init_store) &&
      o_LEVEL_CODE == $past(i_WDATA[6:0])))
    else $error("select 1 write touched initial store");

endmodule : nvc_regs

// [test/nvc_host.sv]
// Host model: issues single byte requests on the decoded register bus.
// Assumes the bank answers at the edge that takes a request, before the next falling edge.
`timescale 1ns/10ps
module nvc_host (
  input wire logic i_mclk,
  input wire logic [7:0] i_rdata,
  input wire logic i_rvalid,
  input wire logic i_ack,
  output logic o_wr = 1'b0,
  output logic o_rd = 1'b0,
  output logic [6:0] o_target = 7'h00,
  output logic [7:0] o_addr = 8'h00,
  output logic [7:0] o_wdata = 8'h00
);
  // ==========================================================================
  // Request at a falling edge, answer taken at the next one
  task automatic xfer(input logic w, input logic [6:0] t, input logic [7:0] a,
                      input logic [7:0] d, output logic [7:0] q, output logic [1:0] k);
    logic [7:0] dd;
    dd = d;
    if (t == nvc_pkg::COMMON_LEVEL_CODE_TARGET && a == nvc_pkg::VDATA_OFS) dd[7] = 1'b0;
    if (t == nvc_pkg::COMMON_LEVEL_CODE_TARGET && a == nvc_pkg::VCTRL_OFS) dd[6:0] = 7'h00;
    @(negedge i_mclk);
    o_wr = w;
    o_rd = !w;
    o_target = t;
    o_addr = a;
    o_wdata = dd;
    @(negedge i_mclk);
    q = i_rdata;
    k = {i_rvalid, i_ack};
    o_wr = 1'b0;
    o_rd = 1'b0;
    // Released lines show the inverse so a stale value cannot pass
    o_target = ~t;
    o_addr = ~a;
    o_wdata = ~dd;
  endtask : xfer
endmodule : nvc_host

// [test/tb.sv]
// Bench for the register bank: host model plus integer reference model.
// Assumes a short copy time through the COPY_CYCLES parameter.
`timescale 1ns/10ps
module tb;
  localparam logic [nvc_pkg::CNT_W-1:0] CC = 20'h00004;
  localparam logic [6:0] CF = nvc_pkg::CFG_TARGET;
  localparam logic [6:0] VT = nvc_pkg::COMMON_LEVEL_CODE_TARGET;
  logic I_MCLK = 1'b0;
  logic I_RST = 1'b1;
  logic wr, rd, rvalid, ack, busy;
  logic [6:0] tgt, lvl;
  logic [7:0] addr, wdata, rdata;
  logic [3:0] upl, lol;
  logic [14:0] tbl [9];
  int fail_count = 0;
  int compares = 0;
  int up = 0, lo = 7, usr = 0, sup = 0, slo = 7, susr = 0;
  int rsel = 0, trig = 0, iv = 64, wk = 64, ssel = 0;

  // ==========================================================================
  // Clock, design and host
  always #2.5 I_MCLK = ~I_MCLK;
  nvc_regs #(.COPY_CYCLES(CC)) i_dut (.I_MCLK(I_MCLK), .I_RST(I_RST), .i_WR(wr), .i_RD(rd),
    .i_TARGET(tgt), .i_ADDR(addr), .i_WDATA(wdata), .o_RDATA(rdata), .o_RVALID(rvalid),
    .o_ACK(ack), .o_COPY_BUSY(busy), .o_LEVEL_CODE(lvl), .o_UPPER_LIMIT(upl),
    .o_LOWER_LIMIT(lol));
  nvc_host i_host (.i_mclk(I_MCLK), .i_rdata(rdata), .i_rvalid(rvalid), .i_ack(ack),
    .o_wr(wr), .o_rd(rd), .o_target(tgt), .o_addr(addr), .o_wdata(wdata));

  // ==========================================================================
  // Checking and reference model
  task automatic chk(input logic [7:0] seen, input logic [7:0] exp, input string what);
    compares++;
    if (seen !== exp) begin
      fail_count++;
      $display("unexpected at %0t: %s seen %h expected %h", $time, what, seen, exp);
    end
  endtask : chk

  function automatic int exp_rd(input logic [6:0] t, input logic [7:0] a);
    if (t == CF && a == nvc_pkg::UPPER_OFS) return rsel ? sup : up;
    if (t == CF && a == nvc_pkg::LOWER_OFS) return rsel ? slo : lo;
    if (t == CF && a == nvc_pkg::USER_OFS) return rsel ? susr : usr;
    if (t == CF && a == nvc_pkg::CTRL_OFS) return trig * 128 + rsel;
    if (t == VT && a == nvc_pkg::VDATA_OFS) return ssel ? wk : iv;
    return 0;
  endfunction : exp_rd

  function automatic logic mapped(input logic [6:0] t, input logic [7:0] a);
    return (t == CF && (a inside {8'h13, 8'h14, 8'h15, 8'hff})) ||
           (t == VT && (a inside {8'h00, 8'h02}));
  endfunction : mapped

  // One transfer, model update and port comparisons
  task automatic op(input logic w, input logic [6:0] t, input logic [7:0] a, input logic [7:0] d);
    logic [7:0] q;
    logic [1:0] k;
    int e;
    e = exp_rd(t, a);
    i_host.xfer(w, t, a, d, q, k);
    chk({7'h00, k[0]}, {7'h00, mapped(t, a)}, "ack");
    if (!w) begin
      chk({7'h00, k[1]}, 8'h01, "rvalid");
      chk(q, 8'(e), "read data");
    end else if (t == CF) begin
      if (a == nvc_pkg::UPPER_OFS) up = d[3:0];
      if (a == nvc_pkg::LOWER_OFS) lo = d[3:0];
      if (a == nvc_pkg::USER_OFS) usr = d;
      if (a == nvc_pkg::CTRL_OFS) rsel = d[0];
      if (a == nvc_pkg::CTRL_OFS && d[7]) trig = 1;
    end else if (t == VT && a == nvc_pkg::VDATA_OFS) begin
      if (!ssel) iv = d[6:0];
      wk = d[6:0];
    end else if (t == VT && a == nvc_pkg::VCTRL_OFS) begin
      ssel = d[7];
    end
    chk({1'b0, lvl}, 8'(wk), "level code");
    chk({upl, lol}, 8'(up * 16 + lo), "limits");
    chk({7'h00, busy}, 8'(trig), "busy");
  endtask : op

  // Start a copy and measure how long busy stands
  task automatic copy_now(input logic [7:0] d);
    int n;
    n = 0;
    op(1'b1, CF, nvc_pkg::CTRL_OFS, d | 8'h80);
    while (busy === 1'b1 && n < 20) begin
      @(negedge I_MCLK);
      n++;
    end
    chk(8'(n), 8'(CC), "copy length");
    sup = up;
    slo = lo;
    susr = usr;
    trig = 0;
  endtask : copy_now

  task automatic results();
    $display("compares %0d mismatches %0d", compares, fail_count);
    if (fail_count == 0 && compares > 0) $display("Result: passed");
    else $display("Result: failed");
    $finish;
  endtask : results

  // ==========================================================================
  // Main sequence
  initial begin
    tbl = '{{CF, 8'h13}, {CF, 8'h14}, {CF, 8'h15}, {VT, 8'h00}, {VT, 8'h02},
            {CF, 8'h16}, {VT, 8'h01}, {7'h21, 8'h15}, {CF, 8'hff}};
    void'($urandom(32'ha22e5696));
    repeat (10) @(negedge I_MCLK);
    I_RST = 1'b0;
    // Reset values, unmapped places included
    for (int i = 0; i < 9; i++) op(1'b0, tbl[i][14:8], tbl[i][7:0], 8'h00);
    $display("test reset values done");
    // Directed: both store selects and the stored-copy read path, never left to chance
    op(1'b1, VT, nvc_pkg::VCTRL_OFS, 8'h80);
    op(1'b1, VT, nvc_pkg::VDATA_OFS, 8'h15);
    op(1'b0, VT, nvc_pkg::VDATA_OFS, 8'h00);
    op(1'b1, VT, nvc_pkg::VCTRL_OFS, 8'h00);
    op(1'b0, VT, nvc_pkg::VDATA_OFS, 8'h00);
    op(1'b1, CF, nvc_pkg::USER_OFS, 8'h5a);
    op(1'b1, CF, nvc_pkg::CTRL_OFS, 8'h01);
    op(1'b0, CF, nvc_pkg::USER_OFS, 8'h00);
    $display("test directed selects done");
    // Random writes and readback, copies between passes
    repeat (6) begin
      for (int i = 0; i < 8; i++) op(1'b1, tbl[i][14:8], tbl[i][7:0], 8'($urandom));
      op(1'b1, CF, nvc_pkg::CTRL_OFS, 8'($urandom) & 8'h7f);
      for (int i = 0; i < 9; i++) op(1'b0, tbl[i][14:8], tbl[i][7:0], 8'h00);
      copy_now(8'($urandom));
      for (int i = 0; i < 9; i++) op(1'b0, tbl[i][14:8], tbl[i][7:0], 8'h00);
      $display("test random pass done");
    end
    results();
  end

  // Watchdog well beyond the expected run
  initial begin
    repeat (20000) @(posedge I_MCLK);
    fail_count++;
    $display("unexpected at %0t: watchdog expired", $time);
    results();
  end
endmodule : tb
